/* include/ics_pkg.sv */
package ics_pkg;
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] work;
      logic [7:0] bank_sel;
      logic [7:0] latch_hi;
      logic [7:0] latch_up;
      logic [7:0] fp0l;
      logic [7:0] fp0h;
      logic [7:0] fp1l;
      logic [7:0] fp1h;
      logic [7:0] fp2l;
      logic [7:0] fp2h;
      logic [7:0] prod_lo;
      logic [7:0] prod_hi;
   } ics_ctx_t;
   typedef enum logic [1:0] {LV_MAIN, LV_LOW, LV_HIGH} ics_level_t;
   typedef struct packed {
      ics_level_t level;
      logic       low_over_main;
      logic       high_saved_main;
   } ics_lvl_t;
endpackage

/* include/ics_regs.svh */
`ifndef ICS_REGS_SVH
`define ICS_REGS_SVH
`define ICS_SHADOW_BANK   6'h38
`define ICS_OFS_STATUS    8'h84
`define ICS_OFS_WORK      8'h85
`define ICS_OFS_BANKSEL   8'h86
`define ICS_OFS_LATCH_HI  8'h87
`define ICS_OFS_LATCH_UP  8'h88
`define ICS_OFS_FP0L      8'h89
`define ICS_OFS_FP0H      8'h8A
`define ICS_OFS_FP1L      8'h8B
`define ICS_OFS_FP1H      8'h8C
`define ICS_OFS_FP2L      8'h8D
`define ICS_OFS_FP2H      8'h8E
`define ICS_OFS_PROD_LO   8'h8F
`define ICS_OFS_PROD_HI   8'h90
`define ICS_OFS_VIEWCTL   8'h83
`define ICS_BIT_LEVELSEL  0
`define ICS_CTX_MAIN      1'b0
`define ICS_CTX_LOW       1'b1
`endif

/* rtl/ics_ctx_save.sv */
`timescale 1ns/1ps
`include "ics_regs.svh"
// automatic context save/restore between cpu and shadow banks
module ics_ctx_save (
   input  wire logic              CLOCK_I,
   input  wire logic              RST_I,
   input  wire logic              PRIORITY_LEVELS_ENABLE_I,
   input  wire logic              MULTI_VECTOR_ENABLE_I,
   input  wire logic              ENTRY_LOW_I,
   input  wire logic              ENTRY_HIGH_I,
   input  wire logic [7:0]        VECTOR_I,
   input  wire logic [20:0]       PC_I,
   input  wire logic              RETURN_I,
   input  ics_pkg::ics_ctx_t      CPU_CTX_I,
   input  wire logic              SFR_WE_I,
   input  wire logic [13:0]       SFR_ADDR_I,
   input  wire logic [7:0]        SFR_WDATA_I,
   output logic [7:0]             SFR_RDATA_O,
   output logic                   RESTORE_O,
   output ics_pkg::ics_ctx_t      RESTORE_CTX_O,
   output logic                   LOAD_WORK_O,
   output logic [7:0]             WORK_VALUE_O,
   output logic                   PC_PUSH_O,
   output logic [20:0]            PC_PUSH_DATA_O,
   output logic                   SHADOW_LEVEL_SELECT_O
);
   typedef struct packed {
      ics_pkg::ics_lvl_t lvl;
      logic              level_sel;
      logic [7:0]        rdata;
      logic              restore;
      logic              load_work;
      logic [7:0]        work_value;
      logic              push;
      logic [20:0]       push_data;
   } ics_st_t;
   ics_st_t            st_ff;
   ics_st_t            nxt_st;
   logic               mem_we;
   logic               mem_wsel;
   ics_pkg::ics_ctx_t  mem_wdata;
   logic               rest_sel;
   ics_pkg::ics_ctx_t  rest_ctx;
   ics_pkg::ics_ctx_t  view_ctx;
   logic               in_bank;
   logic [7:0]         ofs;

   // byte lane of a context by shadow offset
   function automatic logic [7:0] ctx_byte(input ics_pkg::ics_ctx_t c, input logic [7:0] o);
      unique case (o)
         `ICS_OFS_STATUS:  ctx_byte = c.status;
         `ICS_OFS_WORK:    ctx_byte = c.work;
         `ICS_OFS_BANKSEL: ctx_byte = c.bank_sel;
         `ICS_OFS_LATCH_HI: ctx_byte = c.latch_hi;
         `ICS_OFS_LATCH_UP: ctx_byte = c.latch_up;
         `ICS_OFS_FP0L:    ctx_byte = c.fp0l;
         `ICS_OFS_FP0H:    ctx_byte = c.fp0h;
         `ICS_OFS_FP1L:    ctx_byte = c.fp1l;
         `ICS_OFS_FP1H:    ctx_byte = c.fp1h;
         `ICS_OFS_FP2L:    ctx_byte = c.fp2l;
         `ICS_OFS_FP2H:    ctx_byte = c.fp2h;
         `ICS_OFS_PROD_LO: ctx_byte = c.prod_lo;
         `ICS_OFS_PROD_HI: ctx_byte = c.prod_hi;
         default:          ctx_byte = 8'h00;
      endcase
   endfunction

   assign in_bank = (SFR_ADDR_I[13:8] == `ICS_SHADOW_BANK);
   assign ofs     = SFR_ADDR_I[7:0];

   // save/restore sequencing and software shadow writes
   always_comb begin
      nxt_st           = st_ff;
      nxt_st.restore   = 1'b0;
      nxt_st.load_work = 1'b0;
      nxt_st.push      = 1'b0;
      mem_we           = 1'b0;
      mem_wsel         = `ICS_CTX_MAIN;
      mem_wdata        = CPU_CTX_I;
      rest_sel         = `ICS_CTX_MAIN;
      // multi vector setting deliberately unused here
      if (ENTRY_HIGH_I || ENTRY_LOW_I) begin
         nxt_st.push      = 1'b1;
         nxt_st.push_data = PC_I;
         nxt_st.load_work = 1'b1;
         nxt_st.work_value = VECTOR_I;
         mem_we           = 1'b1;
         unique case (st_ff.lvl.level)
            ics_pkg::LV_MAIN: begin
               mem_wsel = `ICS_CTX_MAIN;
               if (ENTRY_HIGH_I || !PRIORITY_LEVELS_ENABLE_I) begin
                  nxt_st.lvl.level = ics_pkg::LV_HIGH;
                  nxt_st.lvl.high_saved_main = 1'b1;
               end else begin
                  nxt_st.lvl.level = ics_pkg::LV_LOW;
               end
            end
            ics_pkg::LV_LOW: begin
               mem_wsel = `ICS_CTX_LOW;
               nxt_st.lvl.level = ics_pkg::LV_HIGH;
               nxt_st.lvl.high_saved_main = 1'b0;
            end
            ics_pkg::LV_HIGH: begin
               mem_we = 1'b0; // high level: push and vector only, no save, level stays high
            end
            default: begin
               mem_we = 1'b0; // undefined level: no save, back to main
               nxt_st.lvl.level = ics_pkg::LV_MAIN;
            end
         endcase
      end else if (RETURN_I) begin
         nxt_st.restore = 1'b1;
         unique case (st_ff.lvl.level)
            ics_pkg::LV_HIGH: begin
               if (st_ff.lvl.high_saved_main) begin
                  rest_sel = `ICS_CTX_MAIN;
                  nxt_st.lvl.level = ics_pkg::LV_MAIN;
               end else begin
                  rest_sel = `ICS_CTX_LOW;
                  nxt_st.lvl.level = ics_pkg::LV_LOW;
               end
            end
            ics_pkg::LV_LOW: begin
               rest_sel = `ICS_CTX_MAIN;
               nxt_st.lvl.level = ics_pkg::LV_MAIN;
            end
            ics_pkg::LV_MAIN: begin
               nxt_st.restore = 1'b0;
            end
            default: begin
               nxt_st.restore = 1'b0; // undefined level: no restore
               nxt_st.lvl.level = ics_pkg::LV_MAIN;
            end
         endcase
      end else if (SFR_WE_I && in_bank) begin
         if (ofs == `ICS_OFS_VIEWCTL) begin
            nxt_st.level_sel = SFR_WDATA_I[`ICS_BIT_LEVELSEL];
         end else if (ofs >= `ICS_OFS_STATUS && ofs <= `ICS_OFS_PROD_HI) begin
            mem_we    = 1'b1;
            mem_wsel  = st_ff.level_sel;
            mem_wdata = view_ctx;
            unique case (ofs)
               `ICS_OFS_STATUS:  mem_wdata.status   = SFR_WDATA_I;
               `ICS_OFS_WORK:    mem_wdata.work     = SFR_WDATA_I;
               `ICS_OFS_BANKSEL: mem_wdata.bank_sel = SFR_WDATA_I;
               `ICS_OFS_LATCH_HI: mem_wdata.latch_hi = SFR_WDATA_I;
               `ICS_OFS_LATCH_UP: mem_wdata.latch_up = SFR_WDATA_I;
               `ICS_OFS_FP0L:    mem_wdata.fp0l     = SFR_WDATA_I;
               `ICS_OFS_FP0H:    mem_wdata.fp0h     = SFR_WDATA_I;
               `ICS_OFS_FP1L:    mem_wdata.fp1l     = SFR_WDATA_I;
               `ICS_OFS_FP1H:    mem_wdata.fp1h     = SFR_WDATA_I;
               `ICS_OFS_FP2L:    mem_wdata.fp2l     = SFR_WDATA_I;
               `ICS_OFS_FP2H:    mem_wdata.fp2h     = SFR_WDATA_I;
               `ICS_OFS_PROD_LO: mem_wdata.prod_lo  = SFR_WDATA_I;
               default:          mem_wdata.prod_hi  = SFR_WDATA_I;
            endcase
         end
      end
      // registered read of the selected view
      if (!in_bank) begin
         nxt_st.rdata = 8'h00;
      end else if (ofs == `ICS_OFS_VIEWCTL) begin
         nxt_st.rdata = {7'h00, st_ff.level_sel};
      end else begin
         nxt_st.rdata = ctx_byte(view_ctx, ofs);
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // context banks, restore value registered outside in restore_ctx_ff
   ics_shadow_mem ics_shadow_mem_i (
      .clk_i   (CLOCK_I),
      .rst_i   (RST_I),
      .we_i    (mem_we),
      .wsel_i  (mem_wsel),
      .wdata_i (mem_wdata),
      .rsel_i  (rest_sel),
      .rdata_o (rest_ctx),
      .vsel_i  (st_ff.level_sel),
      .vdata_o (view_ctx)
   );

   // restore data captured alongside the strobe
   ics_pkg::ics_ctx_t restore_ctx_ff;
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         restore_ctx_ff <= '0;
      end else begin
         restore_ctx_ff <= rest_ctx;
      end
   end

   assign RESTORE_CTX_O         = restore_ctx_ff;
   assign SFR_RDATA_O           = st_ff.rdata;
   assign RESTORE_O             = st_ff.restore;
   assign LOAD_WORK_O           = st_ff.load_work;
   assign WORK_VALUE_O          = st_ff.work_value;
   assign PC_PUSH_O             = st_ff.push;
   assign PC_PUSH_DATA_O        = st_ff.push_data;
   assign SHADOW_LEVEL_SELECT_O = st_ff.level_sel;
endmodule // ics_ctx_save

/* rtl/ics_shadow_mem.sv */
`timescale 1ns/1ps
`include "ics_regs.svh"
// two-entry context store, combinational read of the stored banks
module ics_shadow_mem (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             we_i,
   input  wire logic             wsel_i,
   input  ics_pkg::ics_ctx_t     wdata_i,
   input  wire logic             rsel_i,
   output ics_pkg::ics_ctx_t     rdata_o,
   input  wire logic             vsel_i,
   output ics_pkg::ics_ctx_t     vdata_o
);
   typedef struct packed {
      ics_pkg::ics_ctx_t [1:0] bank;
   } ics_mem_st_t;
   ics_mem_st_t st_ff;
   ics_mem_st_t nxt_st;
   // write port
   always_comb begin
      nxt_st = st_ff;
      if (we_i) begin
         nxt_st.bank[wsel_i] = wdata_i;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign rdata_o = st_ff.bank[rsel_i];
   assign vdata_o = st_ff.bank[vsel_i];
endmodule // ics_shadow_mem

/* tb/ics_checker.sv */
`timescale 1ns/1ps
// port checks of the context save block
module ics_checker (
   input wire logic        CLOCK_I,
   input wire logic        RST_I,
   input wire logic        ENTRY_LOW_I,
   input wire logic        ENTRY_HIGH_I,
   input wire logic [7:0]  VECTOR_I,
   input wire logic [20:0] PC_I,
   input wire logic        RETURN_I,
   input wire logic        SFR_WE_I,
   input wire logic [13:0] SFR_ADDR_I,
   input wire logic [7:0]  SFR_WDATA_I,
   input wire logic [7:0]  SFR_RDATA_O,
   input wire logic        RESTORE_O,
   input wire logic        LOAD_WORK_O,
   input wire logic [7:0]  WORK_VALUE_O,
   input wire logic        PC_PUSH_O,
   input wire logic [20:0] PC_PUSH_DATA_O,
   input wire logic        SHADOW_LEVEL_SELECT_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   // entry and plain software write
   wire ent = ENTRY_LOW_I | ENTRY_HIGH_I;
   wire swr = SFR_WE_I && !ent && !RETURN_I;
   wire vw  = swr && SFR_ADDR_I == 14'h3883;
   sequence s_wr; swr && SFR_ADDR_I == 14'h3885; endsequence
   sequence s_rd; !SFR_WE_I && !ent && !RETURN_I && $stable(SFR_ADDR_I); endsequence
   property p_push; ent |=> PC_PUSH_O && PC_PUSH_DATA_O == $past(PC_I); endproperty
   property p_load; ent |=> LOAD_WORK_O && WORK_VALUE_O == $past(VECTOR_I); endproperty
   property p_quiet; !ent |=> !PC_PUSH_O && !LOAD_WORK_O; endproperty
   property p_norst; !RETURN_I || ent |=> !RESTORE_O; endproperty
   property p_sel; vw |=> SHADOW_LEVEL_SELECT_O == $past(SFR_WDATA_I[0]); endproperty
   property p_hold; !vw |=> $stable(SHADOW_LEVEL_SELECT_O); endproperty
   property p_bank; SFR_ADDR_I[13:8] != 6'h38 |=> SFR_RDATA_O == 8'h00; endproperty
   property p_wb; s_wr ##1 s_rd |=> SFR_RDATA_O == $past(SFR_WDATA_I, 2); endproperty
   a_push: assert property (p_push) else $error("pc push wrong");
   a_load: assert property (p_load) else $error("vector load wrong");
   a_quiet: assert property (p_quiet) else $error("stray entry pulse");
   a_norst: assert property (p_norst) else $error("stray restore");
   a_sel: assert property (p_sel) else $error("view bit wrong");
   a_hold: assert property (p_hold) else $error("view bit moved");
   a_bank: assert property (p_bank) else $error("read outside bank");
   a_wb: assert property (p_wb) else $error("shadow readback wrong");
endmodule // ics_checker
bind ics_ctx_save ics_checker ics_checker_i (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
   .ENTRY_LOW_I(ENTRY_LOW_I), .ENTRY_HIGH_I(ENTRY_HIGH_I), .VECTOR_I(VECTOR_I),
   .PC_I(PC_I), .RETURN_I(RETURN_I), .SFR_WE_I(SFR_WE_I), .SFR_ADDR_I(SFR_ADDR_I),
   .SFR_WDATA_I(SFR_WDATA_I), .SFR_RDATA_O(SFR_RDATA_O), .RESTORE_O(RESTORE_O),
   .LOAD_WORK_O(LOAD_WORK_O), .WORK_VALUE_O(WORK_VALUE_O), .PC_PUSH_O(PC_PUSH_O),
   .PC_PUSH_DATA_O(PC_PUSH_DATA_O), .SHADOW_LEVEL_SELECT_O(SHADOW_LEVEL_SELECT_O));

/* tb/ics_cpu_model.sv */
`timescale 1ns/1ps
// cpu register file: takes restored context, else the bench's value
module ics_cpu_model (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         set_i,
   input  ics_pkg::ics_ctx_t set_ctx_i,
   input  wire logic         restore_i,
   input  ics_pkg::ics_ctx_t restore_ctx_i,
   output ics_pkg::ics_ctx_t ctx_o
);
   // restore beats a bench load
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) ctx_o <= '0;
      else if (restore_i) ctx_o <= restore_ctx_i;
      else if (set_i) ctx_o <= set_ctx_i;
   end
endmodule // ics_cpu_model

/* tb/ics_ctx_save_tb.sv */
`timescale 1ns/1ps
module ics_ctx_save_tb;
   logic clk, rst, priority_levels_enable, mvec, elo, ehi, ret, we, setc, rs, lw, pp, sel;
   logic [7:0] vec, wd, rd, wv;
   logic [20:0] pc, pd;
   logic [13:0] addr;
   ics_pkg::ics_ctx_t cin, ctx, rctx;
   int n_fail = 0;
   int check_count = 0;
   ics_ctx_save ics_ctx_save_i (.CLOCK_I(clk), .RST_I(rst), .PRIORITY_LEVELS_ENABLE_I(priority_levels_enable),
      .MULTI_VECTOR_ENABLE_I(mvec), .ENTRY_LOW_I(elo), .ENTRY_HIGH_I(ehi), .VECTOR_I(vec),
      .PC_I(pc), .RETURN_I(ret), .CPU_CTX_I(ctx), .SFR_WE_I(we), .SFR_ADDR_I(addr),
      .SFR_WDATA_I(wd), .SFR_RDATA_O(rd), .RESTORE_O(rs), .RESTORE_CTX_O(rctx),
      .LOAD_WORK_O(lw), .WORK_VALUE_O(wv), .PC_PUSH_O(pp), .PC_PUSH_DATA_O(pd),
      .SHADOW_LEVEL_SELECT_O(sel));
   ics_cpu_model ics_cpu_model_i (.clk_i(clk), .rst_i(rst), .set_i(setc), .set_ctx_i(cin),
      .restore_i(rs), .restore_ctx_i(rctx), .ctx_o(ctx));
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (n_fail == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic step;
      @(posedge clk);
      #2;
   endtask
   function automatic ics_pkg::ics_ctx_t mk(input logic [7:0] b);
      for (int i = 0; i < 13; i++) mk[i*8+:8] = b + 8'(i);
   endfunction
   // cpu holds c, then vectors to a routine
   task automatic enter(input logic hi, input logic [7:0] v, input ics_pkg::ics_ctx_t c);
      cin = c;
      setc = 1;
      step;
      setc = 0;
      elo = !hi;
      ehi = hi;
      vec = v;
      pc = {13'h0, v};
      step;
      elo = 0;
      ehi = 0;
      chk(pp, 1);
      chk(pd, {13'h0, v});
      chk(wv, v);
   endtask
   // return; cpu must then hold e
   task automatic leave(input ics_pkg::ics_ctx_t e);
      cin = mk(8'hE0); // routine scribbles over the cpu registers
      setc = 1;
      ret = 1;
      step;
      setc = 0;
      ret = 0;
      chk(rs, 1);
      step;
      chk(ctx, e);
   endtask
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      we = 1;
      step;
      we = 0;
   endtask
   task automatic rdchk(input logic [13:0] a, input logic [7:0] e);
      addr = a;
      step;
      chk(rd, e);
   endtask
   // nesting main, low, high under both vector settings
   task automatic t_nest;
      for (int m = 0; m < 2; m++) begin
         mvec = m[0];
         enter(0, 8'h21, mk(8'h10));
         enter(1, 8'h32, mk(8'h40));
         leave(mk(8'h40));
         leave(mk(8'h10));
         ret = 1;
         step;
         ret = 0;
         chk(rs, 0);
      end
   endtask
   // high over main, then single level
   task automatic t_levels;
      enter(1, 8'h05, mk(8'h70));
      leave(mk(8'h70));
      priority_levels_enable = 0;
      enter(0, 8'h06, mk(8'h80));
      enter(0, 8'h07, mk(8'h90));
      leave(mk(8'h80));
      priority_levels_enable = 1;
   endtask
   // shadow view, edit and readback
   task automatic t_sfr;
      ics_pkg::ics_ctx_t e;
      e = mk(8'h50);
      enter(0, 8'h11, e);
      enter(1, 8'h12, mk(8'hA0));
      wr(14'h3883, 8'h01);
      chk(sel, 1);
      rdchk(14'h3884, 8'hAC);
      wr(14'h3883, 8'h00);
      rdchk(14'h3885, 8'h5B);
      wr(14'h3885, 8'h77);
      rdchk(14'h3885, 8'h77);
      rdchk(14'h0085, 8'h00);
      leave(mk(8'hA0));
      e.work = 8'h77;
      leave(e);
   endtask
   initial begin
      {rst, priority_levels_enable, mvec, elo, ehi, ret, we, setc} = 8'hC0;
      {vec, wd, pc, addr, cin} = '0;
      repeat (4) @(posedge clk);
      #2 rst = 0;
      chk({pp, lw, rs, sel}, 0);
      t_nest;
      t_levels;
      t_sfr;
      give_verdict;
   end
   // hang guard, far beyond the run length
   initial begin
      #20000;
      n_fail++;
      give_verdict;
   end
endmodule // ics_ctx_save_tb
